// File: catm_host.sv
/*
  Terminal-side transport controller: takes command messages from the
  application, runs the character-protocol exchange (header, procedure bytes,
  data, fetch-remaining and resend-with-length) or maps them into block-protocol
  information fields, and returns the response message and status.
  Assumes a byte link layer below (tx with ready, rx without) and an application
  that accepts every response byte.
*/
// Behaviour
// - case 4 trailing expected-length byte is never sent to the card.
// - after header, data goes only after a procedure byte; status with no fetch or resend due ends command.
// - fetch-remaining header length equals the length from the card.
// - case 4 warning or application status after data gives fetch with length zero.
// - any other status after case 4 data ends the command.
// - a fetch command is run exactly as a case 2 command.
// - resend code on a case 2 command makes the previous header go again with the new length; on other cases it is an error.
// - block protocol carries command and response fields unchanged.
// - block protocol commands longer than one field are chained over blocks.
// - block protocol response is one field or chained fields concatenated.
`timescale 1ns/1ps
`default_nettype none
`include "catm_consts.svh"

module catm_host
  import catm_pkg::*;
#(
  parameter int IFSC       = `CATM_IFSC_DEF,
  parameter int FIFO_DEPTH = `CATM_FIFO_DEPTH
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       proto_t1,
  input  wire logic [1:0] cmd_case,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic [7:0]      tx_data,
  output logic            tx_last,
  output logic            tx_chain,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_last,
  input  wire logic       rx_chain,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_last,
  output logic            done,
  output logic [7:0]      sw1,
  output logic [7:0]      sw2,
  output logic            proto_err
);
  // ************************************************
  // command buffer
  // ************************************************
  logic                    fifo_ov, fifo_pop;
  logic [`CATM_FIFO_W-1:0] fifo_data;

  catm_fifo #(.W(`CATM_FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_last, cmd_data}),
    .out_valid (fifo_ov),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ************************************************
  // state
  // ************************************************
  catm_state_type state_q, state_d;
  catm_case_type  case_q, case_d;
  logic [7:0] hdr_q [0:4];
  logic [7:0] hdr_d [0:4];
  logic [2:0] idx_q, idx_d;
  logic [7:0] left_q, left_d, blk_cnt_q, blk_cnt_d;
  logic [8:0] rx_left_q, rx_left_d;
  logic       one_q, one_d, gr_q, gr_d, data_done_q, data_done_d;
  logic       last_seen_q, last_seen_d, t1_q, t1_d, err_q, err_d, done_q, done_d;
  logic [7:0] sw1_q, sw1_d, sw2_q, sw2_d, tx_data_q, tx_data_d, rsp_data_q, rsp_data_d;
  logic       tx_valid_q, tx_valid_d, tx_last_q, tx_last_d, tx_chain_q, tx_chain_d;
  logic       rsp_valid_q, rsp_valid_d, rsp_last_q, rsp_last_d;
  logic       tx_free, blk_end;
  logic       c_null, c_ack_all, c_ack_one, c_sw1, c_more, c_relen, c_cont;

  catm_sw_class u_class (
    .rx_byte    (rx_data),
    .sw1_in     (sw1_q),
    .ins        (hdr_q[`CATM_IDX_INS]),
    .is_null    (c_null),
    .is_ack_all (c_ack_all),
    .is_ack_one (c_ack_one),
    .is_sw1     (c_sw1),
    .is_more    (c_more),
    .is_relen   (c_relen),
    .is_cont    (c_cont)
  );

  assign tx_free = !tx_valid_q || tx_ready;
  assign blk_end = fifo_data[8] || (blk_cnt_q == 8'(IFSC - 1));

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb
  begin
    state_d     = state_q;
    case_d      = case_q;
    hdr_d       = hdr_q;
    idx_d       = idx_q;
    left_d      = left_q;
    blk_cnt_d   = blk_cnt_q;
    rx_left_d   = rx_left_q;
    one_d       = one_q;
    gr_d        = gr_q;
    data_done_d = data_done_q;
    last_seen_d = last_seen_q;
    t1_d        = t1_q;
    err_d       = err_q;
    sw1_d       = sw1_q;
    sw2_d       = sw2_q;
    tx_data_d   = tx_data_q;
    tx_last_d   = tx_last_q;
    tx_chain_d  = tx_chain_q;
    tx_valid_d  = tx_valid_q && !tx_ready;
    rsp_data_d  = rsp_data_q;
    rsp_valid_d = 1'b0;
    rsp_last_d  = 1'b0;
    done_d      = 1'b0;
    fifo_pop    = 1'b0;
    case (state_q)
      ST_IDLE:
        if (fifo_ov)
        begin
          t1_d        = proto_t1;
          case_d      = catm_case_type'(cmd_case);
          err_d       = 1'b0;
          gr_d        = 1'b0;
          data_done_d = 1'b0;
          last_seen_d = 1'b0;
          idx_d       = 3'h0;
          blk_cnt_d   = 8'h00;
          state_d     = proto_t1 ? ST_T1_TX : ST_HDR_LD;
        end
      ST_HDR_LD:
        if (fifo_ov)
        begin
          fifo_pop     = 1'b1;
          hdr_d[idx_q] = fifo_data[7:0];
          last_seen_d  = fifo_data[8];
          idx_d        = idx_q + 3'h1;
          if (idx_q == `CATM_HDR_LAST)
          begin
            idx_d   = 3'h0;
            // case 4 sends Lc data bytes only; the Le byte behind them stays queued
            left_d  = (case_q == CASE_3 || case_q == CASE_4) ? fifo_data[7:0] : 8'h00;
            state_d = ST_HDR_TX;
          end
        end
      ST_HDR_TX:
        if (tx_free)
        begin
          tx_valid_d = 1'b1;
          tx_data_d  = hdr_q[idx_q];
          tx_last_d  = 1'b0;
          tx_chain_d = 1'b0;
          idx_d      = idx_q + 3'h1;
          if (idx_q == `CATM_HDR_LAST)
          begin
            idx_d     = 3'h0;
            // zero length asks for a full 256-byte answer
            rx_left_d = (case_q != CASE_2) ? 9'h000 :
                        (hdr_q[`CATM_IDX_P3] == 8'h00) ? `CATM_LEN_FULL :
                        {1'b0, hdr_q[`CATM_IDX_P3]};
            state_d   = ST_PROC_WAIT;
          end
        end
      ST_PROC_WAIT:
        if (rx_valid)
        begin
          if (c_null)
            state_d = ST_PROC_WAIT;
          else if (c_ack_all || c_ack_one)
          begin
            one_d = c_ack_one;
            if (left_q != 8'h00)
              state_d = ST_DATA_TX;
            else if (rx_left_q != 9'h000)
              state_d = ST_RX_DATA;
            else
            begin
              err_d   = 1'b1;
              state_d = ST_DRAIN;
            end
          end
          else if (c_sw1)
          begin
            sw1_d   = rx_data;
            state_d = ST_SW2_WAIT;
          end
          else
          begin
            err_d   = 1'b1;
            state_d = ST_DRAIN;
          end
        end
      ST_DATA_TX:
        if (tx_free && fifo_ov)
        begin
          fifo_pop    = 1'b1;
          tx_valid_d  = 1'b1;
          tx_data_d   = fifo_data[7:0];
          last_seen_d = fifo_data[8];
          left_d      = left_q - 8'h01;
          if (one_q || left_q == 8'h01)
            state_d = ST_PROC_WAIT;
          if (left_q == 8'h01)
            data_done_d = (case_q == CASE_4);
        end
      ST_RX_DATA:
        if (rx_valid)
        begin
          rsp_valid_d = 1'b1;
          rsp_data_d  = rx_data;
          rx_left_d   = rx_left_q - 9'h001;
          if (one_q || rx_left_q == 9'h001)
            state_d = ST_PROC_WAIT;
        end
      ST_SW2_WAIT:
        if (rx_valid)
        begin
          sw2_d = rx_data;
          if (c_more && (case_q == CASE_2 || data_done_q))
          begin
            hdr_d[`CATM_IDX_INS] = `CATM_INS_GETRSP;
            hdr_d[`CATM_IDX_P1]  = 8'h00;
            hdr_d[`CATM_IDX_P2]  = 8'h00;
            hdr_d[`CATM_IDX_P3]  = rx_data;
            case_d      = CASE_2;
            gr_d        = 1'b1;
            left_d      = 8'h00;
            data_done_d = 1'b0;
            state_d     = ST_HDR_TX;
          end
          else if (c_relen && case_q == CASE_2)
          begin
            hdr_d[`CATM_IDX_P3] = rx_data;
            state_d             = ST_HDR_TX;
          end
          else if (c_more || c_relen)
          begin
            err_d   = 1'b1;
            state_d = ST_DRAIN;
          end
          else if (data_done_q && c_cont)
          begin
            hdr_d[`CATM_IDX_INS] = `CATM_INS_GETRSP;
            hdr_d[`CATM_IDX_P1]  = 8'h00;
            hdr_d[`CATM_IDX_P2]  = 8'h00;
            hdr_d[`CATM_IDX_P3]  = 8'h00;
            case_d      = CASE_2;
            gr_d        = 1'b1;
            data_done_d = 1'b0;
            state_d     = ST_HDR_TX;
          end
          else
            state_d = ST_DRAIN;
        end
      ST_DRAIN:
        // discards the unsent remainder of the command, Le included
        if (last_seen_q)
        begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
        else if (fifo_ov)
        begin
          fifo_pop    = 1'b1;
          last_seen_d = fifo_data[8];
        end
      ST_T1_TX:
        if (tx_free && fifo_ov)
        begin
          fifo_pop   = 1'b1;
          tx_valid_d = 1'b1;
          tx_data_d  = fifo_data[7:0];
          tx_last_d  = blk_end;
          tx_chain_d = blk_end && !fifo_data[8];
          blk_cnt_d  = blk_end ? 8'h00 : blk_cnt_q + 8'h01;
          if (fifo_data[8])
            state_d = ST_T1_RX;
        end
      ST_T1_RX:
        if (rx_valid)
        begin
          rsp_valid_d = 1'b1;
          rsp_data_d  = rx_data;
          sw1_d       = sw2_q;
          sw2_d       = rx_data;
          if (rx_last && !rx_chain)
          begin
            rsp_last_d = 1'b1;
            done_d     = 1'b1;
            state_d    = ST_IDLE;
          end
        end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q     <= ST_IDLE;
      case_q      <= CASE_1;
      hdr_q       <= '{default: 8'h00};
      idx_q       <= 3'h0;
      left_q      <= 8'h00;
      blk_cnt_q   <= 8'h00;
      rx_left_q   <= 9'h000;
      one_q       <= 1'b0;
      gr_q        <= 1'b0;
      data_done_q <= 1'b0;
      last_seen_q <= 1'b0;
      t1_q        <= 1'b0;
      err_q       <= 1'b0;
      done_q      <= 1'b0;
      sw1_q       <= 8'h00;
      sw2_q       <= 8'h00;
      tx_valid_q  <= 1'b0;
      tx_data_q   <= 8'h00;
      tx_last_q   <= 1'b0;
      tx_chain_q  <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_last_q  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      case_q      <= case_d;
      hdr_q       <= hdr_d;
      idx_q       <= idx_d;
      left_q      <= left_d;
      blk_cnt_q   <= blk_cnt_d;
      rx_left_q   <= rx_left_d;
      one_q       <= one_d;
      gr_q        <= gr_d;
      data_done_q <= data_done_d;
      last_seen_q <= last_seen_d;
      t1_q        <= t1_d;
      err_q       <= err_d;
      done_q      <= done_d;
      sw1_q       <= sw1_d;
      sw2_q       <= sw2_d;
      tx_valid_q  <= tx_valid_d;
      tx_data_q   <= tx_data_d;
      tx_last_q   <= tx_last_d;
      tx_chain_q  <= tx_chain_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
      rsp_last_q  <= rsp_last_d;
    end
  end

  assign tx_valid  = tx_valid_q;
  assign tx_data   = tx_data_q;
  assign tx_last   = tx_last_q;
  assign tx_chain  = tx_chain_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;
  assign rsp_last  = rsp_last_q;
  assign done      = done_q;
  assign sw1       = sw1_q;
  assign sw2       = sw2_q;
  assign proto_err = err_q;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_sw2_seen;
    state_q == ST_SW2_WAIT && rx_valid;
  endsequence

  sequence s_fetch_due;
    s_sw2_seen ##0 (c_more && (case_q == CASE_2 || data_done_q));
  endsequence

  a_fetch_len_match: assert property (s_fetch_due |=> state_q == ST_HDR_TX &&
    hdr_q[1] == `CATM_INS_GETRSP && hdr_q[4] == $past(rx_data) && case_q == CASE_2)
    else $error("fetch header length differs from card length");

  a_fetch_warn_zero: assert property (s_sw2_seen ##0 (!c_more && !c_relen &&
    data_done_q && c_cont) |=> state_q == ST_HDR_TX && hdr_q[4] == 8'h00 && gr_q)
    else $error("warning status after data did not start zero-length fetch");

  a_status_stops: assert property (s_sw2_seen ##0 (!c_more && !c_relen &&
    !(data_done_q && c_cont)) |=> state_q == ST_DRAIN && !tx_valid_q)
    else $error("status did not end the command");

  a_resend_relen: assert property (s_sw2_seen ##0 (c_relen && case_q == CASE_2)
    |=> state_q == ST_HDR_TX && idx_q == 3'h0 && hdr_q[4] == $past(rx_data))
    else $error("resend header lacks corrected length");

  a_fetch_case_two: assert property ((state_q == ST_HDR_TX && idx_q == 3'h4 &&
    tx_free && gr_q) |=> rx_left_q == (($past(hdr_q[4]) == 8'h00) ? 9'h100 :
    {1'b0, $past(hdr_q[4])}))
    else $error("fetch not run as case 2");

  a_data_after_ack: assert property ((state_q != ST_DATA_TX ##1 state_q == ST_DATA_TX)
    |-> $past(state_q) == ST_PROC_WAIT && $past(c_ack_all || c_ack_one))
    else $error("data sent without procedure byte");

  a_drain_silent: assert property (state_q == ST_DRAIN |=> !$rose(tx_valid_q)
    ##1 !$rose(tx_valid_q))
    else $error("byte sent while discarding remainder");

  a_bad_proc_err: assert property ((state_q == ST_PROC_WAIT && rx_valid && !c_null &&
    !c_ack_all && !c_ack_one && !c_sw1) |=> proto_err && state_q == ST_DRAIN)
    else $error("bad procedure byte not flagged");

  a_t1_chain_cut: assert property ((state_q == ST_T1_TX && tx_free && fifo_ov &&
    !fifo_data[8] && blk_cnt_q == 8'(IFSC - 1)) |=> tx_valid_q && tx_last_q && tx_chain_q)
    else $error("full block not chained");

  a_t1_rsp_copy: assert property ((state_q == ST_T1_RX && rx_valid) |=> rsp_valid &&
    rsp_data == $past(rx_data) && rsp_last == $past(rx_last && !rx_chain))
    else $error("block response not passed unchanged");

endmodule

`default_nettype wire

// File: catm_consts.svh
/*
  Constants for the card message transport controller: procedure-byte and status
  codes, header layout, block size and FIFO shape.
  Assumes it is included by bare name from the design files.
*/
`ifndef CATM_CONSTS_SVH
`define CATM_CONSTS_SVH

// ************************************************
// header layout
// ************************************************
`define CATM_HDR_LEN      5
`define CATM_HDR_LAST     3'h4
`define CATM_IDX_INS      3'h1
`define CATM_IDX_P1       3'h2
`define CATM_IDX_P2       3'h3
`define CATM_IDX_P3       3'h4
`define CATM_LEN_FULL     9'h100

// ************************************************
// procedure bytes and status codes
// ************************************************
`define CATM_INS_GETRSP   8'hC0
`define CATM_PB_NULL      8'h60
`define CATM_SW1_MORE     8'h61
`define CATM_SW1_WARN_A   8'h62
`define CATM_SW1_WARN_B   8'h63
`define CATM_SW1_RELEN    8'h6C
`define CATM_SW1_OK       8'h90
`define CATM_SW2_OK       8'h00
`define CATM_NIB_SW6      4'h6
`define CATM_NIB_SW9      4'h9

// ************************************************
// block protocol and buffering
// ************************************************
`define CATM_IFSC_DEF     32
`define CATM_FIFO_DEPTH   16
`define CATM_FIFO_W       9

`endif

// File: catm_pkg.sv
/*
  Types for the card message transport controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package catm_pkg;

  typedef enum logic [1:0] {CASE_1, CASE_2, CASE_3, CASE_4} catm_case_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HDR_LD,
    ST_HDR_TX,
    ST_PROC_WAIT,
    ST_DATA_TX,
    ST_RX_DATA,
    ST_SW2_WAIT,
    ST_DRAIN,
    ST_T1_TX,
    ST_T1_RX
  } catm_state_type;

endpackage

// File: catm_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides; ready toward the writer is
  registered. Assumes DEPTH is a power of two and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module catm_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          full_q, full_d;
  logic          push, pop;

  // ************************************************
  // pointers and count
  // ************************************************
  always_comb
  begin
    push   = in_valid && !full_q;
    pop    = out_ready && (cnt_q != '0);
    wr_d   = push ? wr_q + AW'(1) : wr_q;
    rd_d   = pop ? rd_q + AW'(1) : rd_q;
    cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    full_d = (cnt_d == (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
    end
    else
    begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      full_q <= full_d;
    end
  end

  // storage needs no reset; only the pointers and count define what is valid
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  assign in_ready  = !full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

endmodule

`default_nettype wire

// File: catm_sw_class.sv
/*
  Classifies a byte from the card as a procedure byte or status, and a completed
  status pair as one that continues a case 4 exchange.
  Assumes inputs are stable within the cycle; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "catm_consts.svh"

module catm_sw_class (
  input  wire logic [7:0] rx_byte,
  input  wire logic [7:0] sw1_in,
  input  wire logic [7:0] ins,
  output logic            is_null,
  output logic            is_ack_all,
  output logic            is_ack_one,
  output logic            is_sw1,
  output logic            is_more,
  output logic            is_relen,
  output logic            is_cont
);
  always_comb
  begin
    is_null    = (rx_byte == `CATM_PB_NULL);
    is_ack_all = (rx_byte == ins);
    is_ack_one = (rx_byte == ~ins);
    is_sw1     = ((rx_byte[7:4] == `CATM_NIB_SW6) && !is_null) ||
                 (rx_byte[7:4] == `CATM_NIB_SW9);
    is_more    = (sw1_in == `CATM_SW1_MORE);
    is_relen   = (sw1_in == `CATM_SW1_RELEN);
    // rx_byte is the second status byte here
    is_cont    = (sw1_in == `CATM_SW1_WARN_A) || (sw1_in == `CATM_SW1_WARN_B) ||
                 ((sw1_in[7:4] == `CATM_NIB_SW9) &&
                  !((sw1_in == `CATM_SW1_OK) && (rx_byte == `CATM_SW2_OK)));
  end

endmodule

`default_nettype wire

// File: catm_card_model.sv
/*
  Behavioural card: answers headers, takes data, returns procedure bytes,
  data and status. Assumes one clock and a host keeping the byte handshake.
*/
`timescale 1ns/1ps
`default_nettype none
`include "catm_consts.svh"

module catm_card_model (
  input  wire logic        core_clk,
  input  wire logic        proto_t1,
  input  wire logic        has_data,
  input  wire logic        stall,
  input  wire logic [8:0]  luicc,
  input  wire logic [15:0] err_sw,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  input  wire logic        tx_chain,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_last,
  output logic             rx_chain
);
  logic [9:0]  seen [$];
  logic [9:0]  w;
  logic [39:0] h;
  logic [8:0]  rem_q;
  logic [8:0]  le;
  logic [7:0]  k;

  assign tx_ready = !stall;

  // idle line toggles so a stale value never reads as a byte
  task automatic send(input logic [7:0] b, input logic l = 1'b0, input logic c = 1'b0);
    repeat (2) @(posedge core_clk) rx_data <= ~rx_data;
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_last <= l;
    rx_chain <= c;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_chain <= 1'b0;
    rx_data <= ~b;
  endtask

  task automatic send2(input logic [15:0] s);
    send(s[15:8]);
    send(s[7:0]);
  endtask

  task automatic getb();
    do @(posedge core_clk); while (!(tx_valid && tx_ready));
    w = {tx_chain & tx_last, tx_last, tx_data};
    h = {h[31:0], tx_data};
    seen.push_back(w);
  endtask

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_chain = 1'b0;
    k = 8'h00;
    rem_q = 9'h000;
    forever
    begin
      getb();
      if (proto_t1)
      begin
        while (w[9:8] != 2'b01) getb();
        send(8'hA0, 1'b1, 1'b1);
        // the closing field must carry rx_last, or the host never ends the response
        send(8'hA1);
        send(`CATM_SW1_OK);
        send(`CATM_SW2_OK, 1'b1);
      end
      else
      begin
        repeat (4) getb();
        le = (h[7:0] == 8'h00) ? `CATM_LEN_FULL : {1'b0, h[7:0]};
        if (h[31:24] != `CATM_INS_GETRSP) rem_q = luicc;
        if (has_data && h[31:24] != `CATM_INS_GETRSP)
        begin
          send(h[31:24]);
          repeat (h[7:0]) getb();
          if (err_sw != 16'h0000) send2(err_sw);
          else send2({`CATM_SW1_MORE, rem_q[7:0]});
        end
        else if (le > rem_q || (h[7:0] == 8'h00 && rem_q < `CATM_LEN_FULL))
          send2({`CATM_SW1_RELEN, rem_q[7:0]});
        else
        begin
          send(h[31:24]);
          repeat (le)
          begin
            send(8'hA0 ^ k);
            k++;
          end
          rem_q = rem_q - le;
          if (rem_q == 9'h000) send2({`CATM_SW1_OK, `CATM_SW2_OK});
          else send2({`CATM_SW1_MORE, rem_q[7:0]});
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench: controller against the card model.
  Assumes the design files and catm_card_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        proto_t1 = 1'b0;
  logic [1:0]  cmd_case = 2'h0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_data = 8'h00;
  logic        cmd_last = 1'b0;
  logic        has_data = 1'b0;
  logic        stall = 1'b0;
  logic [8:0]  luicc = 9'h000;
  logic [15:0] err_sw = 16'h0000;
  logic        saw_full = 1'b0;
  logic [8:0]  rq [$];
  logic [7:0]  ek = 8'h00;
  int          ndone = 0;
  int          miscompares = 0;
  int          n_tests = 0;
  wire logic   tx_valid, tx_ready, tx_last, tx_chain, rx_valid, rx_last, rx_chain;
  wire logic   cmd_ready, rsp_valid, rsp_last, done, proto_err;
  wire logic [7:0] tx_data, rx_data, rsp_data, sw1, sw2;

  always #2.5 core_clk = ~core_clk;

  // short fields so chaining shows within a small command
  catm_host #(.IFSC(8)) uut (.core_clk, .arst_n, .proto_t1, .cmd_case, .cmd_valid,
    .cmd_ready, .cmd_data, .cmd_last, .tx_valid, .tx_ready, .tx_data, .tx_last,
    .tx_chain, .rx_valid, .rx_data, .rx_last, .rx_chain, .rsp_valid, .rsp_data,
    .rsp_last, .done, .sw1, .sw2, .proto_err);
  catm_card_model card (.core_clk, .proto_t1, .has_data, .stall, .luicc, .err_sw,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_chain, .rx_valid, .rx_data,
    .rx_last, .rx_chain);

  always @(posedge core_clk)
  begin
    if (rsp_valid === 1'b1) rq.push_back({rsp_last, rsp_data});
    if (done === 1'b1) ndone++;
  end

  // ********
  // helpers
  // ********
  task automatic check(input logic [15:0] s, input logic [15:0] e, input string m);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic go(input logic t, input logic [1:0] cs, input logic hd,
                    input logic [8:0] lu, input logic [15:0] er, input logic [7:0] c [$]);
    int i;
    int n0;
    @(negedge core_clk);
    proto_t1 = t;
    cmd_case = cs;
    has_data = hd;
    luicc = lu;
    err_sw = er;
    rq = {};
    card.seen = {};
    n0 = ndone;
    i = 0;
    while (i < c.size())
    begin
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_data = c[i];
      cmd_last = (i == c.size() - 1);
      if (cmd_ready === 1'b1) i++;
      else saw_full = 1'b1;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_last = 1'b0;
    for (i = 0; i < 4000 && ndone == n0; i++) @(negedge core_clk);
    check(ndone - n0, 1, "done");
    check(proto_err, cs == 2'h0 && hd, "err");
  endtask

  task automatic chk(input logic [7:0] e [$], input int n, input logic [15:0] s);
    check(card.seen.size(), e.size(), "tx n");
    foreach (e[i]) check(card.seen[i], {2'b00, e[i]}, "tx");
    check(rq.size(), n, "rsp n");
    foreach (rq[i])
    begin
      check(rq[i], {8'h00, 8'hA0 ^ ek}, "rsp");
      ek++;
    end
    check({sw1, sw2}, s, "sw");
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_c2;
    go(1'b0, 2'h1, 1'b0, 9'h004, 16'h0000, {8'h00, 8'hB0, 8'h00, 8'h00, 8'h04});
    chk({8'h00, 8'hB0, 8'h00, 8'h00, 8'h04}, 4, 16'h9000);
    go(1'b0, 2'h1, 1'b0, 9'h003, 16'h0000, {8'h00, 8'hB0, 8'h00, 8'h00, 8'h06});
    chk({8'h00, 8'hB0, 8'h00, 8'h00, 8'h06, 8'h00, 8'hB0, 8'h00, 8'h00, 8'h03}, 3,
        16'h9000);
    go(1'b0, 2'h1, 1'b0, 9'h005, 16'h0000, {8'h00, 8'hB0, 8'h00, 8'h00, 8'h02});
    chk({8'h00, 8'hB0, 8'h00, 8'h00, 8'h02, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h03}, 5,
        16'h9000);
    $display("case 2 tests done");
  endtask

  task automatic t_c4;
    go(1'b0, 2'h3, 1'b1, 9'h003, 16'h0000, {8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11,
       8'h22, 8'h00});
    chk({8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11, 8'h22, 8'h00, 8'hC0, 8'h00, 8'h00,
         8'h03}, 3, 16'h9000);
    go(1'b0, 2'h3, 1'b1, 9'h002, 16'h6281, {8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11,
       8'h22, 8'h00});
    chk({8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11, 8'h22, 8'h00, 8'hC0, 8'h00, 8'h00,
         8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h02}, 2, 16'h9000);
    go(1'b0, 2'h3, 1'b1, 9'h002, 16'h6A80, {8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11,
       8'h22, 8'h00});
    chk({8'h00, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h11, 8'h22}, 0, 16'h6A80);
    // case 1 acknowledged by the card has nothing to send: abandoned as an error
    go(1'b0, 2'h0, 1'b1, 9'h000, 16'h9000, {8'h00, 8'h10, 8'h00, 8'h00, 8'h00});
    repeat (20) @(negedge core_clk);
    check(card.seen.size(), 5, "c1 n");
    $display("case 4 tests done");
  endtask

  task automatic t_block;
    logic [7:0] c [$];
    logic [8:0] er [4] = '{9'h0A0, 9'h0A1, 9'h090, 9'h100};
    for (int i = 0; i < 20; i++) c.push_back(8'h40 + 8'(i));
    stall = 1'b1;
    fork
      go(1'b1, 2'h2, 1'b0, 9'h000, 16'h0000, c);
      begin
        repeat (40) @(negedge core_clk);
        stall = 1'b0;
      end
    join
    check(saw_full, 1'b1, "full");
    check(card.seen.size(), 20, "blk n");
    foreach (c[i]) check(card.seen[i], {i == 7 || i == 15, i % 8 == 7 || i == 19, c[i]},
                         "blk tx");
    check(rq.size(), 4, "blk rsp n");
    foreach (er[i]) check(rq[i], er[i], "blk rsp");
    check({sw1, sw2}, 16'h9000, "blk sw");
    $display("block test done");
  endtask

  initial
  begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    t_c2;
    t_c4;
    t_block;
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("unexpected at %0t: watchdog", $time);
    wrap_up;
  end
endmodule
`default_nettype wire
